// ===== hw/artmr_top.v
// auto-reload timer, one 16-bit or two 8-bit counters, on the special function register bus
// Operation
// - split clear: one 16-bit auto-reload timer
// - 16-bit rollover reloads and sets high flag
// - 16-bit overflow requests interrupt when enabled
// - low byte wrap interrupts when low enable set
// - split set: two independent 8-bit reload timers
// - run gates all, or high byte in split
// - per-byte select in split (16-bit uses the low select): system clock or shared slow source, /12 or ext/8 by control bit 0
// - external divided clock synchronised before use
// - byte wrap sets its own overflow flag
// - split: high or enabled low wrap interrupts
// - flags cleared only by software write
// - control bits 4 and 1 read zero
// - control at C8, bit-addressable, resets zero
// - reload bytes at CA and CB, read/write
// - count bytes at CC and CD, read/write
`timescale 1ns/10ps
`include "artmr_defines.vh"
module artmr_top (
   // clock and reset
   input wire CLK,
   input wire RST,
   // special function register bus
   input wire [7:0] SFR_ADDR,
   input wire [7:0] SFR_WDATA,
   input wire SFR_WR,
   input wire SFR_RD,
   output reg [7:0] SFR_RDATA,
   // bit access to the control register
   input wire [2:0] SFR_BIT_SEL,
   input wire SFR_BIT_WR,
   input wire SFR_BIT_VAL,
   // per-byte clock selects from the clock control register
   input wire HIGH_BYTE_CLOCK_SELECT,
   input wire LOW_BYTE_CLOCK_SELECT,
   // external oscillator, asynchronous
   input wire EXT_OSC,
   // interrupt controller
   input wire TIMER_INT_ENABLE,
   output wire TIMER_IRQ
);
   reg [7:0] ctrl_r;
   reg [7:0] ctrl_nxt;
   reg [7:0] rld_lo_r;
   reg [7:0] rld_hi_r;
   reg [3:0] div12_r;
   reg [2:0] ext_sync_r;
   reg [2:0] div8_r;
   reg ext_tick_r;
   reg ext_lvl_r;
   // per-byte vectors, index 0 is the low byte and 1 the high byte
   wire [1:0] byte_wr;
   wire [1:0] byte_inc;
   wire [1:0] byte_reload;
   wire [1:0] byte_wrap;
   wire [15:0] byte_rld;
   wire [15:0] byte_cnt;
   wire [7:0] cnt_lo;
   wire [7:0] cnt_hi;
   wire lo_wrap;
   wire hi_wrap;
   wire sys12_tick;
   wire ext_agree;
   wire ext_rise;
   wire slow_tick;
   wire lo_tick;
   wire hi_tick;
   wire lo_inc;
   wire hi_inc;
   wire split;
   wire run;
   wire wr_ctrl;
   wire wr_lo;
   wire wr_hi;
   wire hovf_set;
   wire lovf_set;

   assign split = ctrl_r[`ARTMR_BIT_SPLIT];
   assign run = ctrl_r[`ARTMR_BIT_RUN];
   assign wr_ctrl = SFR_WR && (SFR_ADDR == `ARTMR_ADDR_CTRL);
   assign wr_lo = SFR_WR && (SFR_ADDR == `ARTMR_ADDR_CNT_LO);
   assign wr_hi = SFR_WR && (SFR_ADDR == `ARTMR_ADDR_CNT_HI);

   // ****************************************
   // clock sources
   // ****************************************
   // system clock divided by 12
   always @(posedge CLK) begin
      if (RST) begin
         div12_r <= 4'h0;
      end else if (div12_r == (`ARTMR_SYS_DIV - 4'h1)) begin
         div12_r <= 4'h0;
      end else begin
         div12_r <= div12_r + 4'h1;
      end
   end
   assign sys12_tick = (div12_r == (`ARTMR_SYS_DIV - 4'h1));

   // external oscillator: three-stage sync, a level counts once stages two and three agree, then divide by 8
   always @(posedge CLK) begin
      if (RST) begin
         ext_sync_r <= 3'h0;
         ext_lvl_r <= 1'b0;
         div8_r <= 3'h0;
         ext_tick_r <= 1'b0;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], EXT_OSC};
         if (ext_agree) begin
            ext_lvl_r <= ext_sync_r[2];
         end
         ext_tick_r <= ext_rise && (div8_r == `ARTMR_EXT_DIV);
         if (ext_rise) begin
            div8_r <= div8_r + 3'h1;
         end
      end
   end
   // accepted level starts low like the idle pin, so reset gives no false edge
   assign ext_agree = (ext_sync_r[1] == ext_sync_r[2]);
   assign ext_rise = ext_agree && ext_sync_r[2] && !ext_lvl_r;

   // per-byte source selection
   assign slow_tick = ctrl_r[`ARTMR_BIT_XCLK] ? ext_tick_r : sys12_tick;
   assign lo_tick = LOW_BYTE_CLOCK_SELECT ? 1'b1 : slow_tick;
   assign hi_tick = HIGH_BYTE_CLOCK_SELECT ? 1'b1 : slow_tick;

   // ****************************************
   // counting
   // ****************************************
   // 16-bit: whole timer on run with low byte clock, high carries from low
   // split: low always runs, high gated by run
   assign lo_inc = split ? lo_tick : (run && lo_tick);
   assign hi_inc = split ? (run && hi_tick) : (run && lo_tick && cnt_lo == 8'hFF);

   // per-byte controls and results
   assign byte_wr = {wr_hi, wr_lo};
   assign byte_inc = {hi_inc, lo_inc};
   assign byte_reload = {hi_wrap, (split ? lo_wrap : (lo_wrap && hi_wrap))};
   assign byte_rld = {rld_hi_r, rld_lo_r};
   assign cnt_lo = byte_cnt[7:0];
   assign cnt_hi = byte_cnt[15:8];
   assign lo_wrap = byte_wrap[0];
   assign hi_wrap = byte_wrap[1];

   // one count byte for each half of the timer
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_byte
         artmr_byte u_byte (
            .CLK(CLK),
            .RST(RST),
            .WR(byte_wr[gi]),
            .WDATA(SFR_WDATA),
            .INC(byte_inc[gi]),
            .RELOAD(byte_reload[gi]),
            .RLD(byte_rld[gi * 8 +: 8]),
            .COUNT(byte_cnt[gi * 8 +: 8]),
            .WRAP(byte_wrap[gi])
         );
      end
   endgenerate

   assign hovf_set = hi_wrap;
   assign lovf_set = lo_wrap;

   // ****************************************
   // registers
   // ****************************************
   // control next value: byte or bit write, then hardware sets win
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = SFR_WDATA & `ARTMR_CTRL_WMASK;
      end else if (SFR_BIT_WR && (SFR_ADDR == `ARTMR_ADDR_CTRL)) begin
         ctrl_nxt[SFR_BIT_SEL] = SFR_BIT_VAL;
         ctrl_nxt = ctrl_nxt & `ARTMR_CTRL_WMASK;
      end
      if (hovf_set) begin
         ctrl_nxt[`ARTMR_BIT_HOVF] = 1'b1;
      end
      if (lovf_set) begin
         ctrl_nxt[`ARTMR_BIT_LOVF] = 1'b1;
      end
   end

   // control and reload registers
   always @(posedge CLK) begin
      if (RST) begin
         ctrl_r <= `ARTMR_RESET_BYTE;
         rld_lo_r <= `ARTMR_RESET_BYTE;
         rld_hi_r <= `ARTMR_RESET_BYTE;
      end else begin
         ctrl_r <= ctrl_nxt;
         if (SFR_WR && (SFR_ADDR == `ARTMR_ADDR_RLD_LO)) begin
            rld_lo_r <= SFR_WDATA;
         end
         if (SFR_WR && (SFR_ADDR == `ARTMR_ADDR_RLD_HI)) begin
            rld_hi_r <= SFR_WDATA;
         end
      end
   end

   // registered read data, zero for unmapped addresses
   always @(posedge CLK) begin
      if (RST) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         case (SFR_ADDR)
            `ARTMR_ADDR_CTRL: SFR_RDATA <= ctrl_r & `ARTMR_CTRL_WMASK;
            `ARTMR_ADDR_RLD_LO: SFR_RDATA <= rld_lo_r;
            `ARTMR_ADDR_RLD_HI: SFR_RDATA <= rld_hi_r;
            `ARTMR_ADDR_CNT_LO: SFR_RDATA <= cnt_lo;
            `ARTMR_ADDR_CNT_HI: SFR_RDATA <= cnt_hi;
            default: SFR_RDATA <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // interrupt request
   // ****************************************
   // level request while an enabled flag stays set
   assign TIMER_IRQ = TIMER_INT_ENABLE && (ctrl_r[`ARTMR_BIT_HOVF] ||
      (ctrl_r[`ARTMR_BIT_LIEN] && ctrl_r[`ARTMR_BIT_LOVF]));
endmodule // artmr_top

// ===== hw/artmr_defines.vh
// constants for the auto-reload timer: addresses, control bit positions, reset values, dividers
`ifndef ARTMR_DEFINES_VH
`define ARTMR_DEFINES_VH
// ****************************************
// register addresses
// ****************************************
`define ARTMR_ADDR_CTRL 8'hC8
`define ARTMR_ADDR_RLD_LO 8'hCA
`define ARTMR_ADDR_RLD_HI 8'hCB
`define ARTMR_ADDR_CNT_LO 8'hCC
`define ARTMR_ADDR_CNT_HI 8'hCD
// ****************************************
// control register bit positions
// ****************************************
`define ARTMR_BIT_HOVF 7
`define ARTMR_BIT_LOVF 6
`define ARTMR_BIT_LIEN 5
`define ARTMR_BIT_SPLIT 3
`define ARTMR_BIT_RUN 2
`define ARTMR_BIT_XCLK 0
`define ARTMR_CTRL_WMASK 8'hED
`define ARTMR_RESET_BYTE 8'h00
// ****************************************
// clock dividers
// ****************************************
`define ARTMR_SYS_DIV 4'hC
`define ARTMR_EXT_DIV 3'h7
`endif

// ===== hw/artmr_byte.v
// one 8-bit count byte with software load, increment and reload
`timescale 1ns/10ps
module artmr_byte (
   // clock and reset
   input wire CLK,
   input wire RST,
   // software write
   input wire WR,
   input wire [7:0] WDATA,
   // counting
   input wire INC,
   input wire RELOAD,
   input wire [7:0] RLD,
   // state
   output reg [7:0] COUNT,
   output wire WRAP
);
   // byte is about to roll over from ff, to 00 or to the reload value
   assign WRAP = INC && (COUNT == 8'hFF);

   // count register, software write wins over counting
   always @(posedge CLK) begin
      if (RST) begin
         COUNT <= 8'h00;
      end else if (WR) begin
         COUNT <= WDATA;
      end else if (RELOAD) begin
         COUNT <= RLD;
      end else if (INC) begin
         COUNT <= COUNT + 8'h01;
      end
   end
endmodule // artmr_byte

// ===== test/artmr_properties.sv
// port assertions for the timer
`timescale 1ns/10ps
module artmr_chk (
   // clock and reset
   input wire CLK,
   input wire RST,
   // register bus and request
   input wire [7:0] SFR_ADDR,
   input wire [7:0] SFR_WDATA,
   input wire SFR_WR,
   input wire SFR_RD,
   input wire [7:0] SFR_RDATA,
   input wire SFR_BIT_WR,
   input wire TIMER_INT_ENABLE,
   input wire TIMER_IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // mapped addresses
   wire map = SFR_ADDR == 8'hC8 || (SFR_ADDR > 8'hC9 && SFR_ADDR < 8'hCE);
   a_unmapped_zero: assert property (SFR_RD && !map |=> SFR_RDATA == 8'h00) else $error("unmapped");
   a_unused_zero: assert property (SFR_RD && SFR_ADDR == 8'hC8 |=> !SFR_RDATA[4] && !SFR_RDATA[1])
      else $error("unused bit");
   a_reset_quiet: assert property (disable iff (1'b0) RST |=> SFR_RDATA == 8'h00 && !TIMER_IRQ)
      else $error("reset state");
   a_irq_needs_ie: assert property (TIMER_IRQ |-> TIMER_INT_ENABLE) else $error("irq no enable");
   a_irq_held: assert property (TIMER_IRQ && !SFR_WR && !SFR_BIT_WR |=> TIMER_IRQ || !TIMER_INT_ENABLE)
      else $error("irq dropped");
   a_reload_lo: assert property (SFR_WR && SFR_ADDR == 8'hCA ##1 !SFR_WR
      ##1 SFR_RD && !SFR_WR && SFR_ADDR == 8'hCA |=> SFR_RDATA == $past(SFR_WDATA, 3)) else $error("reload low");
   a_reload_hi: assert property (SFR_WR && SFR_ADDR == 8'hCB ##1 !SFR_WR
      ##1 SFR_RD && !SFR_WR && SFR_ADDR == 8'hCB |=> SFR_RDATA == $past(SFR_WDATA, 3)) else $error("reload high");
   a_rdata_hold: assert property (!SFR_RD |=> $stable(SFR_RDATA)) else $error("read data moved");
   c_irq: cover property (TIMER_IRQ);
   c_bit: cover property (SFR_BIT_WR);
   c_unmapped: cover property (SFR_RD && !map);
endmodule // artmr_chk
bind artmr_top artmr_chk i_chk (.CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
   .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_BIT_WR(SFR_BIT_WR),
   .TIMER_INT_ENABLE(TIMER_INT_ENABLE), .TIMER_IRQ(TIMER_IRQ));

// ===== test/artmr_cpu.sv
// processor core model on the register bus
`timescale 1ns/10ps
module artmr_cpu (
   // clock
   input wire clk,
   // register bus
   output reg [7:0] addr = 8'h00,
   output reg [7:0] wdata = 8'h00,
   output reg wr = 1'b0,
   output reg rd = 1'b0,
   input wire [7:0] rdata,
   output reg [2:0] bsel = 3'h0,
   output reg bwr = 1'b0,
   output reg bval = 1'b0
);
   // requests rise after an edge, fall after the edge that takes them, then one idle cycle passes
   task wr_byte(input [7:0] a, input [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk) #1 wr = 1'b0;
      @(posedge clk) #1;
   endtask
   task rd_byte(input [7:0] a, output [7:0] d);
      addr = a;
      rd = 1'b1;
      @(posedge clk) #1 rd = 1'b0;
      d = rdata;
      @(posedge clk) #1;
   endtask
   task bit_wr(input [2:0] s, input v);
      addr = 8'hC8;
      bsel = s;
      bval = v;
      bwr = 1'b1;
      @(posedge clk) #1 bwr = 1'b0;
      @(posedge clk) #1;
   endtask
   // handler reads both flags, then clears them
   task service(output [7:0] c);
      rd_byte(8'hC8, c);
      wr_byte(8'hC8, c & 8'h3F);
   endtask
endmodule // artmr_cpu

// ===== test/testbench.sv
// self-checking bench for the timer
`timescale 1ns/10ps
module testbench;
   reg clk = 0;
   reg rst = 1;
   reg ie = 0;
   reg ext = 0;
   reg hsel = 1'b1;
   reg lsel = 1'b1;
   reg [7:0] d;
   integer mismatches = 0;
   integer samples_checked = 0;
   integer n;
   wire [7:0] a, w, r;
   wire [2:0] bs;
   wire wr, rd, bw, bv, irq;
   // system clock and an unrelated oscillator
   always #50 clk = ~clk;
   always #370 ext = ~ext;
   artmr_cpu i_cpu (.clk(clk), .addr(a), .wdata(w), .wr(wr), .rd(rd), .rdata(r), .bsel(bs), .bwr(bw), .bval(bv));
   artmr_top i_dut (.CLK(clk), .RST(rst), .SFR_ADDR(a), .SFR_WDATA(w), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(r),
      .SFR_BIT_SEL(bs), .SFR_BIT_WR(bw), .SFR_BIT_VAL(bv), .HIGH_BYTE_CLOCK_SELECT(hsel),
      .LOW_BYTE_CLOCK_SELECT(lsel), .EXT_OSC(ext), .TIMER_INT_ENABLE(ie), .TIMER_IRQ(irq));
   // byte compare and register read compare
   task chk(input [7:0] g, input [7:0] e);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask
   // cycle count compare against an allowed window
   task chk_rng(input integer g, input integer lo, input integer hi);
      samples_checked = samples_checked + 1;
      if (g < lo || g > hi) begin
         mismatches = mismatches + 1;
         $display("FAIL %0t count %0d outside %0d to %0d", $time, g, lo, hi);
      end
   endtask
   task rc(input [7:0] ad, input [7:0] e);
      i_cpu.rd_byte(ad, d);
      chk(d, e);
   endtask
   // preset counts and control, await the request, then halt the run bit
   task go(input [7:0] lo, input [7:0] hi, input [7:0] c);
      i_cpu.wr_byte(8'hCC, lo);
      i_cpu.wr_byte(8'hCD, hi);
      i_cpu.wr_byte(8'hC8, c);
      for (n = 0; n < 20 && irq !== 1'b1; n = n + 1)
         @(posedge clk) #1;
      chk({7'h00, irq}, 8'h01);
      i_cpu.bit_wr(3'h2, 1'b0);
   endtask
   task t_regs;
      rc(8'hC8, 8'h00);
      rc(8'hC9, 8'h00);
      i_cpu.wr_byte(8'hCA, 8'h5A);
      rc(8'hCA, 8'h5A);
      i_cpu.wr_byte(8'hCB, 8'hA5);
      rc(8'hCB, 8'hA5);
      i_cpu.wr_byte(8'hC8, 8'h12);
      rc(8'hC8, 8'h00);
   endtask
   task t_wide;
      ie = 1'b1;
      go(8'hFE, 8'hFF, 8'h04);
      rc(8'hCD, 8'hA5);
      i_cpu.service(d);
      chk(d, 8'hC0);
      chk({7'h00, irq}, 8'h00);
      go(8'hFE, 8'h00, 8'h24);
      rc(8'hCD, 8'h01);
      i_cpu.service(d);
      chk(d, 8'h60);
   endtask
   task t_split;
      i_cpu.wr_byte(8'hCD, 8'h80);
      i_cpu.wr_byte(8'hCC, 8'hF0);
      i_cpu.wr_byte(8'hC8, 8'h08);
      repeat (20) @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00);
      rc(8'hCD, 8'h80);
      i_cpu.bit_wr(3'h5, 1'b1);
      chk({7'h00, irq}, 8'h01);
      i_cpu.service(d);
      chk(d, 8'h68);
      go(8'h00, 8'hFE, 8'h2C);
      i_cpu.service(d);
      chk(d, 8'hA8);
   endtask
   // slow sources: system clock over 12 in 16-bit mode, then external clock over 8 on both split bytes
   task t_slow;
      lsel = 1'b0;
      hsel = 1'b0;
      i_cpu.wr_byte(8'hC8, 8'h00);
      i_cpu.wr_byte(8'hCC, 8'hFE);
      i_cpu.wr_byte(8'hCD, 8'hFF);
      i_cpu.wr_byte(8'hC8, 8'h04);
      for (n = 0; n < 40 && irq !== 1'b1; n = n + 1)
         @(posedge clk) #1;
      chk_rng(n, 12, 23);
      ie = 1'b0;
      @(posedge clk) #1 chk({7'h00, irq}, 8'h00);
      ie = 1'b1;
      @(posedge clk) #1 chk({7'h00, irq}, 8'h01);
      i_cpu.wr_byte(8'hC8, 8'h00);
      i_cpu.wr_byte(8'hCC, 8'hFE);
      i_cpu.wr_byte(8'hCD, 8'hFE);
      i_cpu.wr_byte(8'hC8, 8'h2D);
      for (n = 0; n < 200 && irq !== 1'b1; n = n + 1)
         @(posedge clk) #1;
      chk_rng(n, 50, 130);
      i_cpu.service(d);
      chk(d, 8'hED);
   endtask
   // main sequence after two cycles of reset
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 0;
      t_regs;
      t_wide;
      t_split;
      t_slow;
      summarize;
   end
   // watchdog
   initial begin
      #100000 mismatches = mismatches + 1;
      summarize;
   end
   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
endmodule // testbench
